/* hw/pin_mux_pkg.sv */
// constants and types shared by the port d / port e pin multiplexer
package pin_mux_pkg;
    localparam int   PORT_D_PINS      = 6;
    localparam int   PORT_E_PINS      = 2;
    localparam int   SEL_BIT_PIN_D0   = 4;
    localparam int   SEL_BIT_PIN_D1   = 5;
    localparam int   CS_FIRST_ON_D    = 2;
    localparam logic PIN_OUT_RST      = 1'b0;
    localparam logic PIN_OE_RST       = 1'b0;
    localparam logic PIN_PULL_RST     = 1'b1;
    localparam logic RECEIVE_IDLE_RST = 1'b1;
    localparam logic SYNC_RST         = 1'b1;

    typedef struct packed {
        logic out;
        logic oe;
        logic pull;
    } pin_drive_t;

    // choose between the gpio path and the peripheral path of one pin
    function automatic pin_drive_t drive_pin(
        input logic periph,
        input logic p_out,
        input logic p_oe,
        input logic g_out,
        input logic g_dir,
        input logic pull
    );
        pin_drive_t d;
        d.out  = periph ? p_out : g_out;
        d.oe   = periph ? p_oe  : g_dir;
        d.pull = pull;
        return d;
    endfunction : drive_pin
endpackage : pin_mux_pkg

/* hw/port_d_e_pin_function_mux.sv */
// pin function multiplexer for port d pins 0..5 and port e pins 0..1
// What this block does
// - d pin 0 resets to gpio; enable 0, select bit 4 pick cs 2 or can tx
// - d pin 1 resets to gpio; enable 1, select bit 5 pick cs 3 or can rx
// - d pins 2..5 reset to gpio; alternates are chip selects 4..7
// - every port d gpio pin has its own input/output direction
// - chip selects 2..7 come programmed from the external memory interface
// - chip selects float while the bus idles unless idle-drive is set
// - clearing port d pull-up bit n turns off pin n pull-up; on at reset
// - e pin 0 resets to input with pull-up, then serial 0 transmit, else gpio with direction
// - e pin 1 resets to serial 0 receive, else gpio with direction
// - clearing port e pull-up bit 0 or 1 turns off that pin's pull-up
`timescale 1ns/1ps
module port_d_e_pin_function_mux
    import pin_mux_pkg::*;
#(
    // value of each select bit that picks the chip select (bit0: d0, bit1: d1)
    parameter logic [1:0] CS_SELECT_VALUE = 2'b00
) (
    input  wire logic                   SYS_CLK_I,
    input  wire logic                   SRST_I,
    input  wire logic [PORT_D_PINS-1:0] PORT_D_PERIPHERAL_ENABLE_I,
    input  wire logic [5:0]             PERIPHERAL_FUNCTION_SELECT_I,
    input  wire logic [PORT_D_PINS-1:0] PORT_D_PULLUP_ENABLE_I,
    input  wire logic [PORT_E_PINS-1:0] PORT_E_PULLUP_ENABLE_I,
    input  wire logic [PORT_E_PINS-1:0] PORT_E_GPIO_ENABLE_I,
    input  wire logic                   BUS_IDLE_DRIVE_I,
    input  wire logic                   BUS_ACTIVE_I,
    input  wire logic [7:2]             CHIP_SELECT_N_I,
    input  wire logic                   SECOND_CAN_TRANSMIT_I,
    input  wire logic                   SERIAL0_TRANSMIT_I,
    input  wire logic [PORT_D_PINS-1:0] GPIO_D_OUT_I,
    input  wire logic [PORT_D_PINS-1:0] GPIO_D_DIR_I,
    input  wire logic [PORT_E_PINS-1:0] GPIO_E_OUT_I,
    input  wire logic [PORT_E_PINS-1:0] GPIO_E_DIR_I,
    input  wire logic [PORT_D_PINS-1:0] PORT_D_PIN_I,
    input  wire logic [PORT_E_PINS-1:0] PORT_E_PIN_I,
    output wire logic [PORT_D_PINS-1:0] PORT_D_PIN_O,
    output wire logic [PORT_D_PINS-1:0] PORT_D_PIN_OE_O,
    output wire logic [PORT_D_PINS-1:0] PORT_D_PULLUP_O,
    output wire logic [PORT_E_PINS-1:0] PORT_E_PIN_O,
    output wire logic [PORT_E_PINS-1:0] PORT_E_PIN_OE_O,
    output wire logic [PORT_E_PINS-1:0] PORT_E_PULLUP_O,
    output wire logic [PORT_D_PINS-1:0] GPIO_D_IN_O,
    output wire logic [PORT_E_PINS-1:0] GPIO_E_IN_O,
    output wire logic                   SECOND_CAN_RECEIVE_O,
    output wire logic                   SERIAL0_RECEIVE_O
);
    pin_drive_t [PORT_D_PINS-1:0] drv_d;
    pin_drive_t [PORT_D_PINS-1:0] next_drv_d;
    pin_drive_t [PORT_E_PINS-1:0] drv_e;
    pin_drive_t [PORT_E_PINS-1:0] next_drv_e;
    logic       [PORT_D_PINS-1:0] meta_d;
    logic       [PORT_D_PINS-1:0] sync_d;
    logic       [PORT_E_PINS-1:0] meta_e;
    logic       [PORT_E_PINS-1:0] sync_e;
    logic                         can_receive;
    logic                         serial_receive;
    logic                         next_can_receive;
    logic                         next_serial_receive;

    // counts come from the package; the chip select range stops at 7
    if (PORT_D_PINS + CS_FIRST_ON_D > 8 ||
        SEL_BIT_PIN_D0 > 5 || SEL_BIT_PIN_D1 > 5) begin : g_bad_cfg
        $error("pin counts or select bits outside the fixed ranges");
    end

    // select decode; polarity comes from the parameter
    wire d0_cs  = PERIPHERAL_FUNCTION_SELECT_I[SEL_BIT_PIN_D0]
                  == CS_SELECT_VALUE[0];
    wire d1_cs  = PERIPHERAL_FUNCTION_SELECT_I[SEL_BIT_PIN_D1]
                  == CS_SELECT_VALUE[1];
    wire can_rx_sel = PORT_D_PERIPHERAL_ENABLE_I[1] && !d1_cs;
    // chip selects drive when the bus is busy or idle-drive is set
    wire cs_oe = BUS_ACTIVE_I || BUS_IDLE_DRIVE_I;

    // can transmit is open drain: only ever pulls low
    wire d0_p_out = d0_cs ? CHIP_SELECT_N_I[2] : 1'b0;
    wire d0_p_oe  = d0_cs ? cs_oe : !SECOND_CAN_TRANSMIT_I;
    wire d1_p_out = d1_cs && CHIP_SELECT_N_I[3];
    wire d1_p_oe  = d1_cs && cs_oe;

    always_comb begin
        next_drv_d[0] = drive_pin(PORT_D_PERIPHERAL_ENABLE_I[0], d0_p_out,
            d0_p_oe, GPIO_D_OUT_I[0], GPIO_D_DIR_I[0],
            PORT_D_PULLUP_ENABLE_I[0]);
        next_drv_d[1] = drive_pin(PORT_D_PERIPHERAL_ENABLE_I[1], d1_p_out,
            d1_p_oe, GPIO_D_OUT_I[1], GPIO_D_DIR_I[1],
            PORT_D_PULLUP_ENABLE_I[1]);
        for (int k = 2; k < PORT_D_PINS; k++) begin
            next_drv_d[k] = drive_pin(PORT_D_PERIPHERAL_ENABLE_I[k],
                CHIP_SELECT_N_I[k+CS_FIRST_ON_D], cs_oe, GPIO_D_OUT_I[k],
                GPIO_D_DIR_I[k], PORT_D_PULLUP_ENABLE_I[k]);
        end
        // port e is peripheral unless its gpio enable is set
        next_drv_e[0] = drive_pin(!PORT_E_GPIO_ENABLE_I[0],
            SERIAL0_TRANSMIT_I, 1'b1, GPIO_E_OUT_I[0], GPIO_E_DIR_I[0],
            PORT_E_PULLUP_ENABLE_I[0]);
        next_drv_e[1] = drive_pin(!PORT_E_GPIO_ENABLE_I[1], 1'b0, 1'b0,
            GPIO_E_OUT_I[1], GPIO_E_DIR_I[1],
            PORT_E_PULLUP_ENABLE_I[1]);
    end

    // receivers see an idle high level when their pin is elsewhere
    assign next_can_receive    = can_rx_sel ? sync_d[1] : 1'b1;
    assign next_serial_receive = PORT_E_GPIO_ENABLE_I[1] ? 1'b1
                                                         : sync_e[1];

    // pins are asynchronous: two flops before anything reads them
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            meta_d <= {PORT_D_PINS{SYNC_RST}};
            sync_d <= {PORT_D_PINS{SYNC_RST}};
            meta_e <= {PORT_E_PINS{SYNC_RST}};
            sync_e <= {PORT_E_PINS{SYNC_RST}};
        end else begin
            meta_d <= PORT_D_PIN_I;
            sync_d <= meta_d;
            meta_e <= PORT_E_PIN_I;
            sync_e <= meta_e;
        end
    end

    // reset puts every pin in input with pull-up on
    always_ff @(posedge SYS_CLK_I) begin
        if (SRST_I) begin
            drv_d          <= {PORT_D_PINS{PIN_OUT_RST, PIN_OE_RST,
                                           PIN_PULL_RST}};
            drv_e          <= {PORT_E_PINS{PIN_OUT_RST, PIN_OE_RST,
                                           PIN_PULL_RST}};
            can_receive    <= RECEIVE_IDLE_RST;
            serial_receive <= RECEIVE_IDLE_RST;
        end else begin
            drv_d          <= next_drv_d;
            drv_e          <= next_drv_e;
            can_receive    <= next_can_receive;
            serial_receive <= next_serial_receive;
        end
    end

    for (genvar g = 0; g < PORT_D_PINS; g++) begin : g_port_d
        assign PORT_D_PIN_O[g]    = drv_d[g].out;
        assign PORT_D_PIN_OE_O[g] = drv_d[g].oe;
        assign PORT_D_PULLUP_O[g] = drv_d[g].pull;
    end
    for (genvar g = 0; g < PORT_E_PINS; g++) begin : g_port_e
        assign PORT_E_PIN_O[g]    = drv_e[g].out;
        assign PORT_E_PIN_OE_O[g] = drv_e[g].oe;
        assign PORT_E_PULLUP_O[g] = drv_e[g].pull;
    end
    assign GPIO_D_IN_O          = sync_d;
    assign GPIO_E_IN_O          = sync_e;
    assign SECOND_CAN_RECEIVE_O = can_receive;
    assign SERIAL0_RECEIVE_O    = serial_receive;

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SRST_I);

    a_d0_gpio_path: assert property (
        !PORT_D_PERIPHERAL_ENABLE_I[0] |=>
            PORT_D_PIN_OE_O[0] == $past(GPIO_D_DIR_I[0]) &&
            PORT_D_PIN_O[0] == $past(GPIO_D_OUT_I[0]))
        else $error("d pin 0 gpio path wrong");

    a_d0_can_drive: assert property (
        PORT_D_PERIPHERAL_ENABLE_I[0] && !d0_cs |=>
            PORT_D_PIN_OE_O[0] == !$past(SECOND_CAN_TRANSMIT_I) &&
            !PORT_D_PIN_O[0])
        else $error("can transmit not open drain on d pin 0");

    a_d1_can_rx: assert property (
        can_rx_sel |=> !PORT_D_PIN_OE_O[1] &&
            SECOND_CAN_RECEIVE_O == $past(sync_d[1]))
        else $error("can receive path wrong on d pin 1");

    a_cs_pin_route: assert property (
        PORT_D_PERIPHERAL_ENABLE_I[4] |=>
            PORT_D_PIN_O[4] == $past(CHIP_SELECT_N_I[6]))
        else $error("chip select 6 not on d pin 4");

    a_gpio_dir_d3: assert property (
        !PORT_D_PERIPHERAL_ENABLE_I[3] ##1 !PORT_D_PERIPHERAL_ENABLE_I[3]
            |=> PORT_D_PIN_OE_O[3] == $past(GPIO_D_DIR_I[3]))
        else $error("d pin 3 direction not followed");

    a_cs_idle_float: assert property (
        PORT_D_PERIPHERAL_ENABLE_I[2] |=>
            PORT_D_PIN_OE_O[2] == ($past(BUS_ACTIVE_I) ||
                                   $past(BUS_IDLE_DRIVE_I)))
        else $error("chip select 4 idle drive wrong");

    a_d_pullup_ctl: assert property (
        1'b1 |=> PORT_D_PULLUP_O == $past(PORT_D_PULLUP_ENABLE_I))
        else $error("port d pull-up mismatch");

    a_e0_serial_tx: assert property (
        !PORT_E_GPIO_ENABLE_I[0] |=> PORT_E_PIN_OE_O[0] &&
            PORT_E_PIN_O[0] == $past(SERIAL0_TRANSMIT_I))
        else $error("serial transmit not on e pin 0");

    a_e1_serial_rx: assert property (
        !PORT_E_GPIO_ENABLE_I[1] |=> !PORT_E_PIN_OE_O[1] &&
            SERIAL0_RECEIVE_O == $past(sync_e[1]))
        else $error("serial receive path wrong on e pin 1");

    a_e_pullup_ctl: assert property (
        1'b1 |=> PORT_E_PULLUP_O == $past(PORT_E_PULLUP_ENABLE_I))
        else $error("port e pull-up mismatch");

    a_e0_reset_state: assert property (disable iff (1'b0)
        SRST_I |=> !PORT_E_PIN_OE_O[0] && PORT_E_PULLUP_O[0])
        else $error("e pin 0 driving during reset");

    a_d0_cs_route: assert property (
        PORT_D_PERIPHERAL_ENABLE_I[0] && d0_cs |=>
            PORT_D_PIN_O[0] == $past(CHIP_SELECT_N_I[2]))
        else $error("chip select 2 not on d pin 0");

    a_d1_cs_drive: assert property (
        PORT_D_PERIPHERAL_ENABLE_I[1] && d1_cs |=>
            PORT_D_PIN_O[1] == $past(CHIP_SELECT_N_I[3]) &&
            PORT_D_PIN_OE_O[1] == ($past(BUS_ACTIVE_I) ||
                                   $past(BUS_IDLE_DRIVE_I)))
        else $error("chip select 3 drive wrong on d pin 1");

    a_in_sync_path: assert property (
        1'b1 |=> {GPIO_D_IN_O, GPIO_E_IN_O} == $past({meta_d, meta_e}))
        else $error("pad input not synchronised in two stages");
endmodule : port_d_e_pin_function_mux

/* sim/pad_model.sv */
// pad and outside-party model for the multiplexed pins
`timescale 1ns/1ps
module pad_model #(
    parameter int N = 6
) (
    input  wire logic         clk_i,
    input  wire logic [N-1:0] out_i,
    input  wire logic [N-1:0] oe_i,
    input  wire logic [N-1:0] pull_i,
    input  wire logic [N-1:0] ext_en_i,
    input  wire logic [N-1:0] ext_val_i,
    output wire logic [N-1:0] pad_o
);
    logic tog = 1'b0;
    // floating pads toggle so a stale level never passes for a match
    always @(posedge clk_i) tog <= ~tog;
    assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i)
                 | (~oe_i & ~ext_en_i & (pull_i | {N{tog}}));
endmodule : pad_model

/* sim/tb_top.sv */
// self-checking bench for the port d / port e pin multiplexer
`timescale 1ns/1ps
module tb_top;
    import pin_mux_pkg::*;
    typedef struct packed {
        logic [5:0] per, sel;
        logic       idle_drive, act;
        logic [5:0] gout, gdir, eout, eoe;
    } row_t;
    logic       clk = 1'b0, srst = 1'b1, idle_drive = 1'b0, act = 1'b0;
    logic       can_tx = 1'b1, ser_tx = 1'b1, can_rx, ser_rx;
    logic [5:0] per = 6'h00, sel = 6'h00, dpu = 6'h3F, gout = 6'h00;
    logic [5:0] gdir = 6'h00, cs_n = 6'h35, dx_en = 6'h00, dx = 6'h00;
    logic [5:0] d_out, d_oe, d_pu, d_pad, d_in;
    logic [1:0] epu = 2'h3, egen = 2'h0, egout = 2'h0, egdir = 2'h0;
    logic [1:0] ex_en = 2'h0, ex = 2'h0, e_out, e_oe, e_pu, e_pad, e_in;
    int         errors = 0, tests_run = 0;
    // cs_n is fixed at 35: chip selects 2..7 = 1,0,1,0,1,1
    row_t rows [6] = '{
        '{6'h00, 6'h00, 1'b0, 1'b0, 6'h2A, 6'h0F, 6'h2A, 6'h0F},
        '{6'h3F, 6'h0F, 1'b0, 1'b1, 6'h00, 6'h00, 6'h35, 6'h3F},
        '{6'h3F, 6'h00, 1'b0, 1'b0, 6'h00, 6'h00, 6'h35, 6'h00},
        '{6'h3F, 6'h00, 1'b1, 1'b0, 6'h00, 6'h00, 6'h35, 6'h3F},
        '{6'h3F, 6'h30, 1'b1, 1'b1, 6'h00, 6'h00, 6'h34, 6'h3C},
        '{6'h01, 6'h10, 1'b0, 1'b0, 6'h00, 6'h02, 6'h00, 6'h02}};

    always #2 clk = ~clk;

    port_d_e_pin_function_mux dut (
        .SYS_CLK_I(clk), .SRST_I(srst), .PORT_D_PERIPHERAL_ENABLE_I(per),
        .PERIPHERAL_FUNCTION_SELECT_I(sel), .PORT_D_PULLUP_ENABLE_I(dpu),
        .PORT_E_PULLUP_ENABLE_I(epu), .PORT_E_GPIO_ENABLE_I(egen),
        .BUS_IDLE_DRIVE_I(idle_drive), .BUS_ACTIVE_I(act),
        .CHIP_SELECT_N_I(cs_n),
        .SECOND_CAN_TRANSMIT_I(can_tx), .SERIAL0_TRANSMIT_I(ser_tx),
        .GPIO_D_OUT_I(gout), .GPIO_D_DIR_I(gdir), .GPIO_E_OUT_I(egout),
        .GPIO_E_DIR_I(egdir), .PORT_D_PIN_I(d_pad), .PORT_E_PIN_I(e_pad),
        .PORT_D_PIN_O(d_out), .PORT_D_PIN_OE_O(d_oe), .PORT_D_PULLUP_O(d_pu),
        .PORT_E_PIN_O(e_out), .PORT_E_PIN_OE_O(e_oe), .PORT_E_PULLUP_O(e_pu),
        .GPIO_D_IN_O(d_in), .GPIO_E_IN_O(e_in),
        .SECOND_CAN_RECEIVE_O(can_rx), .SERIAL0_RECEIVE_O(ser_rx));
    pad_model #(.N(6)) pads_d (.clk_i(clk), .out_i(d_out), .oe_i(d_oe),
        .pull_i(d_pu), .ext_en_i(dx_en), .ext_val_i(dx), .pad_o(d_pad));
    pad_model #(.N(2)) pads_e (.clk_i(clk), .out_i(e_out), .oe_i(e_oe),
        .pull_i(e_pu), .ext_en_i(ex_en), .ext_val_i(ex), .pad_o(e_pad));

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wait_n(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // the whole run needs about forty cycles
    initial begin
        #8000;
        errors++;
        give_verdict();
    end

    initial begin
        wait_n(10);
        chk("rst_d_oe", d_oe, 6'h00);
        chk("rst_pull", {d_pu, e_pu}, 8'hFF);
        chk("rst_e_oe", e_oe, 2'h0);
        chk("rst_in", {d_in, e_in, can_rx, ser_rx}, 10'h3FF);
        @(posedge clk);
        srst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk);
            per <= rows[i].per;
            sel <= rows[i].sel;
            idle_drive <= rows[i].idle_drive;
            act <= rows[i].act;
            gout <= rows[i].gout;
            gdir <= rows[i].gdir;
            wait_n(1);
            chk("d_oe", d_oe, rows[i].eoe);
            chk("d_out", d_out & d_oe, rows[i].eout & rows[i].eoe);
        end
        // open-drain can transmit pulls low only when dominant
        @(posedge clk);
        can_tx <= 1'b0;
        wait_n(1);
        chk("can_tx", {d_oe[0], d_out[0]}, 2'h2);
        @(posedge clk);
        per <= 6'h02;
        sel <= 6'h20;
        dx_en <= 6'h02;
        dpu <= 6'h2A;
        epu <= 2'h1;
        ser_tx <= 1'b0;
        ex_en <= 2'h2;
        wait_n(4);
        chk("can_rx", {can_rx, d_in[1], d_oe[1]}, 3'h0);
        chk("pulls", {d_pu, e_pu}, 8'hA9);
        chk("serial", {ser_rx, e_in[1], e_oe, e_out[0]}, 5'h02);
        @(posedge clk);
        egen <= 2'h3;
        egout <= 2'h2;
        egdir <= 2'h3;
        ex_en <= 2'h0;
        wait_n(4);
        chk("e_gpio", {e_oe, e_out, ser_rx}, 5'h1D);
        @(posedge clk);
        srst <= 1'b1;
        wait_n(1);
        chk("mid_rst", {e_oe, e_pu, d_oe}, 10'h0C0);
        // second release: outputs follow the inputs at the first edge
        @(posedge clk);
        srst <= 1'b0;
        wait_n(1);
        chk("rel_again", {e_oe, e_out, d_pu, e_pu}, 12'hEA9);
        give_verdict();
    end
endmodule : tb_top
